// [inc/csc_pkg.sv]
// Purpose: constants and carriers for the charger status/control bank
// Assumes: 100 MHz clk, byte-wide register port from the serial slave
// Notes: register addresses 0x0a..0x0f only
`default_nettype none
package csc_pkg;
   // ==========================================================
   // register addresses
   localparam logic [7:0] ADDR_STATUS = 8'h0a;
   localparam logic [7:0] ADDR_PART = 8'h0b;
   localparam logic [7:0] ADDR_TZCTL = 8'h0c;
   localparam logic [7:0] ADDR_TZEN = 8'h0d;
   localparam logic [7:0] ADDR_RSVD = 8'h0e;
   localparam logic [7:0] ADDR_FTLED = 8'h0f;
   // ==========================================================
   // field positions
   localparam int BIT_SRC_GOOD = 7;
   localparam int BIT_VLIM = 6;
   localparam int BIT_ILIM = 5;
   localparam int BIT_TOPOFF = 3;
   localparam int BIT_ACOV = 2;
   localparam int BIT_VMASK = 1;
   localparam int BIT_IMASK = 0;
   localparam int BIT_REG_RST = 7;
   // ==========================================================
   // reset values
   localparam logic [7:0] RST_TZCTL = 8'h75;
   localparam logic [7:0] RST_TZEN = 8'h01;
   localparam logic [7:0] RST_FTLED = 8'h00;
   localparam logic [1:0] RST_MASKS = 2'h0;
   localparam logic [7:0] RSVD_VALUE = 8'h00;
   localparam logic [1:0] MON_SEL_STAT = 2'h1;
   // identification, values arbitrary
   localparam logic [3:0] PART_ID = 4'h5;
   localparam logic MAKER_FLAG = 1'b1;
   localparam logic [1:0] REVISION = 2'h0;
   // ==========================================================
   // timing
   localparam longint CLK_HZ = 100_000_000;
   localparam longint BLINK_UNIT_S = 1;
   localparam int BLINK_CYCLES = int'(BLINK_UNIT_S * CLK_HZ);
   // ==========================================================
   // led modes
   typedef enum logic [1:0] {
      CSC_LED_OFF = 2'h0,
      CSC_LED_ON = 2'h1,
      CSC_LED_B11 = 2'h2,
      CSC_LED_B13 = 2'h3
   } csc_led_t;
   // live status inputs
   typedef struct packed {
      logic input_source_good;
      logic input_voltage_limit_active;
      logic input_current_limit_active;
      logic topoff_timer_running;
      logic adapter_overvoltage_flag;
   } csc_status_t;
   // decoded temperature-zone settings
   typedef struct packed {
      logic cool_zone_voltage_select;
      logic cool_zone_charge_enable;
      logic [1:0] warm_zone_current_scale;
      logic [1:0] cool_threshold_select;
      logic [1:0] warm_threshold_select;
      logic temp_zone_adjust_enable;
   } csc_tz_t;
endpackage : csc_pkg
`default_nettype wire

// [core/csc_regs.sv]
// Purpose: status, mask, register-reset and temperature-zone bank
// Assumes: byte port pulses one cycle wide, inputs synchronous to clk
// Notes: read data appears one cycle after the read strobe
`default_nettype none
module csc_regs #(
   parameter int BLINK_CYCLES = csc_pkg::BLINK_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   // charger state
   input wire csc_pkg::csc_status_t status_in,
   input wire logic voltage_limit_event,
   input wire logic current_limit_event,
   input wire logic watchdog_expired,
   input wire logic [1:0] charge_monitor_select,
   input wire logic in_warm_zone,
   input wire logic timer_slow_request,
   // control outputs
   output logic voltage_limit_irq,
   output logic current_limit_irq,
   output logic safety_timer_restart,
   output logic safety_timer_half_rate,
   output csc_pkg::csc_tz_t tz_cfg,
   output logic [7:0] warm_current_pct,
   output logic signed [4:0] fine_tune_mv,
   output logic [6:0] offset_dv,
   output logic [12:0] cool_ratio_bp,
   output logic [12:0] warm_ratio_bp,
   // status pin, oe low while driving
   output logic stat_pin_out,
   output logic stat_pin_oe_n
);
   // ==========================================================
   // storage
   logic [1:0] masks;
   logic [7:0] tzctl;
   logic [7:0] tzen;
   logic [7:0] ftled;
   logic reg_rst_cmd;
   logic [31:0] blink_cnt;
   logic [1:0] sec_cnt;
   logic led_on;
   logic wr_status;
   logic wr_part;
   logic wr_tzctl;
   logic wr_tzen;
   logic wr_ftled;
   logic wd_clr;

   // write decodes
   assign wr_status = reg_wr && reg_addr == csc_pkg::ADDR_STATUS;
   assign wr_part = reg_wr && reg_addr == csc_pkg::ADDR_PART;
   assign wr_tzctl = reg_wr && reg_addr == csc_pkg::ADDR_TZCTL;
   assign wr_tzen = reg_wr && reg_addr == csc_pkg::ADDR_TZEN;
   assign wr_ftled = reg_wr && reg_addr == csc_pkg::ADDR_FTLED;
   assign wd_clr = reg_rst_cmd || watchdog_expired;

   // ==========================================================
   // register reset command, self clearing after one cycle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         reg_rst_cmd <= 1'b0;
      end else if (reg_rst_cmd) begin
         reg_rst_cmd <= 1'b0;
      end else if (wr_part && reg_wdata[csc_pkg::BIT_REG_RST]) begin
         reg_rst_cmd <= 1'b1;
      end
   end

   // safety timer restart pulse
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         safety_timer_restart <= 1'b0;
      end else begin
         safety_timer_restart <= reg_rst_cmd;
      end
   end

   // interrupt masks, register reset only; a same-cycle watchdog drops the write
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         masks <= csc_pkg::RST_MASKS;
      end else if (reg_rst_cmd) begin
         masks <= csc_pkg::RST_MASKS;
      end else if (wr_status && !watchdog_expired) begin
         masks <= reg_wdata[1:0];
      end
   end

   // zone control and enable
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tzctl <= csc_pkg::RST_TZCTL;
         tzen <= csc_pkg::RST_TZEN;
      end else if (wd_clr) begin
         tzctl <= csc_pkg::RST_TZCTL;
         tzen <= csc_pkg::RST_TZEN;
      end else begin
         if (wr_tzctl) begin
            tzctl <= reg_wdata;
         end
         if (wr_tzen) begin
            tzen <= reg_wdata;
         end
      end
   end

   // fine tune, pin, offset; offset survives watchdog
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ftled <= csc_pkg::RST_FTLED;
      end else if (reg_rst_cmd) begin
         ftled <= csc_pkg::RST_FTLED;
      end else if (watchdog_expired) begin
         ftled <= {csc_pkg::RST_FTLED[7:2], ftled[1:0]};
      end else if (wr_ftled) begin
         ftled <= reg_wdata;
      end
   end

   // ==========================================================
   // read path
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            case (reg_addr)
               csc_pkg::ADDR_STATUS: begin
                  reg_rdata <= {status_in.input_source_good,
                     status_in.input_voltage_limit_active,
                     status_in.input_current_limit_active,
                     1'b0,
                     status_in.topoff_timer_running,
                     status_in.adapter_overvoltage_flag,
                     masks};
               end
               csc_pkg::ADDR_PART: begin
                  reg_rdata <= {reg_rst_cmd, csc_pkg::PART_ID, csc_pkg::MAKER_FLAG,
                     csc_pkg::REVISION};
               end
               csc_pkg::ADDR_TZCTL: begin
                  reg_rdata <= tzctl;
               end
               csc_pkg::ADDR_TZEN: begin
                  reg_rdata <= tzen;
               end
               csc_pkg::ADDR_RSVD: begin
                  reg_rdata <= csc_pkg::RSVD_VALUE;
               end
               csc_pkg::ADDR_FTLED: begin
                  reg_rdata <= ftled;
               end
               default: begin
                  reg_rdata <= 8'h00;
               end
            endcase
         end
      end
   end

   // ==========================================================
   // masked event pulses
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         voltage_limit_irq <= 1'b0;
         current_limit_irq <= 1'b0;
      end else begin
         voltage_limit_irq <= voltage_limit_event && !masks[csc_pkg::BIT_VMASK];
         current_limit_irq <= current_limit_event && !masks[csc_pkg::BIT_IMASK];
      end
   end

   // decoded settings
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tz_cfg <= '0;
         warm_current_pct <= 8'h00;
         fine_tune_mv <= 5'sh0;
         offset_dv <= 7'h00;
         cool_ratio_bp <= 13'h0000;
         warm_ratio_bp <= 13'h0000;
         safety_timer_half_rate <= 1'b0;
      end else begin
         tz_cfg <= {tzctl, tzen[0]};
         safety_timer_half_rate <= timer_slow_request && !in_warm_zone;
         case (tzctl[5:4])
            2'h0: warm_current_pct <= 8'h00;
            2'h1: warm_current_pct <= 8'h14;
            2'h2: warm_current_pct <= 8'h32;
            default: warm_current_pct <= 8'h64;
         endcase
         case (tzctl[3:2])
            2'h0: cool_ratio_bp <= 13'h1ba3;
            2'h1: cool_ratio_bp <= 13'h1aa9;
            2'h2: cool_ratio_bp <= 13'h197d;
            default: cool_ratio_bp <= 13'h1851;
         endcase
         case (tzctl[1:0])
            2'h0: warm_ratio_bp <= 13'h12d9;
            2'h1: warm_ratio_bp <= 13'h117b;
            2'h2: warm_ratio_bp <= 13'h0feb;
            default: warm_ratio_bp <= 13'h0ebf;
         endcase
         case (ftled[7:6])
            2'h0: fine_tune_mv <= 5'sh00;
            2'h1: fine_tune_mv <= 5'sh08;
            2'h2: fine_tune_mv <= -5'sh08;
            default: fine_tune_mv <= -5'sh10;
         endcase
         case (ftled[1:0])
            2'h0: offset_dv <= 7'h27;
            2'h1: offset_dv <= 7'h3b;
            2'h2: offset_dv <= 7'h4b;
            default: offset_dv <= 7'h69;
         endcase
      end
   end

   // ==========================================================
   // one-second tick and second counter for blinking
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         blink_cnt <= 32'h0;
         sec_cnt <= 2'h0;
      end else if (blink_cnt == 32'(BLINK_CYCLES - 1)) begin
         blink_cnt <= 32'h0;
         sec_cnt <= sec_cnt + 2'h1;
      end else begin
         blink_cnt <= blink_cnt + 32'h1;
      end
   end

   // led pattern select
   always_comb begin
      case (csc_pkg::csc_led_t'(ftled[3:2]))
         csc_pkg::CSC_LED_OFF: led_on = 1'b0;
         csc_pkg::CSC_LED_ON: led_on = 1'b1;
         csc_pkg::CSC_LED_B11: led_on = !sec_cnt[0];
         csc_pkg::CSC_LED_B13: led_on = sec_cnt == 2'h0;
         default: led_on = 1'b0;
      endcase
   end

   // pin driven low for led on while charge_monitor_select is MON_SEL_STAT, released otherwise
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stat_pin_out <= 1'b0;
         stat_pin_oe_n <= 1'b1;
      end else begin
         stat_pin_out <= 1'b0;
         stat_pin_oe_n <= !(led_on && charge_monitor_select == csc_pkg::MON_SEL_STAT);
      end
   end

   // ==========================================================
   // checks
   property p_rst_self_clear;
      @(posedge clk) disable iff (!rstn) reg_rst_cmd |=> !reg_rst_cmd;
   endproperty
   a_rst_self_clear: assert property (p_rst_self_clear) else $error("reset cmd stuck");
   property p_rst_cmd;
      @(posedge clk) disable iff (!rstn)
         wr_part && reg_wdata[7] && !reg_rst_cmd |=> reg_rst_cmd ##1 safety_timer_restart && tzctl == csc_pkg::RST_TZCTL;
   endproperty
   a_rst_cmd: assert property (p_rst_cmd) else $error("register reset missed");
   property p_wr_zero;
      @(posedge clk) disable iff (!rstn) wr_part && !reg_wdata[7] && !reg_rst_cmd |=> !reg_rst_cmd;
   endproperty
   a_wr_zero: assert property (p_wr_zero) else $error("zero write reset");
   property p_vmask;
      @(posedge clk) disable iff (!rstn) voltage_limit_event |=> voltage_limit_irq == !$past(masks[1]);
   endproperty
   a_vmask: assert property (p_vmask) else $error("voltage irq mask");
   property p_imask;
      @(posedge clk) disable iff (!rstn) current_limit_event |=> current_limit_irq == !$past(masks[0]);
   endproperty
   a_imask: assert property (p_imask) else $error("current irq mask");
   property p_status_rd;
      @(posedge clk) disable iff (!rstn) reg_rd && reg_addr == csc_pkg::ADDR_STATUS |=>
         reg_rvalid && reg_rdata[7:5] == $past(status_in[4:2]) && !reg_rdata[4];
   endproperty
   a_status_rd: assert property (p_status_rd) else $error("status read");
   property p_wd_offset;
      @(posedge clk) disable iff (!rstn) watchdog_expired && !reg_rst_cmd |=>
         ftled[1:0] == $past(ftled[1:0]) && tzen == csc_pkg::RST_TZEN && masks == $past(masks);
   endproperty
   a_wd_offset: assert property (p_wd_offset) else $error("watchdog reset scope");
   property p_warm_timer;
      @(posedge clk) disable iff (!rstn) in_warm_zone |=> !safety_timer_half_rate;
   endproperty
   a_warm_timer: assert property (p_warm_timer) else $error("warm timer doubled");
   property p_pin_gate;
      @(posedge clk) disable iff (!rstn) charge_monitor_select != csc_pkg::MON_SEL_STAT |=> stat_pin_oe_n;
   endproperty
   a_pin_gate: assert property (p_pin_gate) else $error("pin not released");
   property p_rsvd;
      @(posedge clk) disable iff (!rstn) reg_rd && reg_addr == csc_pkg::ADDR_RSVD |=> reg_rdata == csc_pkg::RSVD_VALUE;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved read");
   c_reg_reset: cover property (@(posedge clk) disable iff (!rstn) reg_rst_cmd);
   c_led_on: cover property (@(posedge clk) disable iff (!rstn) !stat_pin_oe_n);
   c_irq: cover property (@(posedge clk) disable iff (!rstn) voltage_limit_irq);
endmodule : csc_regs
`default_nettype wire

// [testbench/csc_host_model.sv]
// Purpose: host side of the byte register port, one strobed byte at a time
// Assumes: requests launched just after a rising edge, held through the taking edge
// Notes: released address and data lines carry the inverse of the last value
`default_nettype none
module csc_host_model (
   // clock
   input wire logic clk,
   // register port
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid
);
   timeunit 1ns;
   timeprecision 100ps;
   // ==========================================================
   // idle bus at time zero
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // one byte after gap idle cycles, released after its taking edge
   task automatic strobe(input logic [7:0] addr, input logic [7:0] data, input logic wr, input int gap);
      repeat (gap) @(posedge clk);
      @(posedge clk);
      reg_addr <= addr;
      reg_wdata <= data;
      reg_wr <= wr;
      reg_rd <= !wr;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      reg_addr <= ~addr;
      reg_wdata <= ~data;
   endtask : strobe
   // write byte; a one in bit 7 of 0x0b asks for register reset
   task automatic write(input logic [7:0] addr, input logic [7:0] data, input int gap);
      strobe(addr, data, 1'b1, gap);
   endtask : write
   // read byte, counting extra cycles waited for the answer
   task automatic read(input logic [7:0] addr, output logic [7:0] data, output int waited);
      strobe(addr, 8'h00, 1'b0, 0);
      #1;
      waited = 0;
      while (reg_rvalid !== 1'b1 && waited < 4) begin
         @(posedge clk);
         #1;
         waited++;
      end
      data = reg_rdata;
   endtask : read
endmodule : csc_host_model
`default_nettype wire

// [testbench/charger_status_control_regs_tb.sv]
// Purpose: self-checking bench of the charger status/control bank
// Assumes: short blink second so that led patterns fit a short run
// Notes: expected values come from tables kept in this bench
`default_nettype none
module charger_status_control_regs_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int BLINK = 8;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   csc_pkg::csc_status_t status_in = '0;
   logic voltage_limit_event = 1'b0, current_limit_event = 1'b0, watchdog_expired = 1'b0;
   logic [1:0] charge_monitor_select = 2'h0;
   logic in_warm_zone = 1'b0, timer_slow_request = 1'b0;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, warm_current_pct;
   logic reg_wr, reg_rd, reg_rvalid, voltage_limit_irq, current_limit_irq;
   logic safety_timer_restart, safety_timer_half_rate, stat_pin_out, stat_pin_oe_n;
   csc_pkg::csc_tz_t tz_cfg;
   logic signed [4:0] fine_tune_mv;
   logic [6:0] offset_dv;
   logic [12:0] cool_ratio_bp, warm_ratio_bp;
   int miscompares = 0, n_compared = 0;
   int pct[4] = '{0, 20, 50, 100};
   int cool[4] = '{7075, 6825, 6525, 6225};
   int warm[4] = '{4825, 4475, 4075, 3775};
   int ft[4] = '{0, 8, -8, -16};
   int offs[4] = '{39, 59, 75, 105};
   logic [7:0] part;
   // open-drain led line with pull-up
   wire logic led_level = stat_pin_oe_n ? 1'b1 : stat_pin_out;
   // ==========================================================
   // clock and parts
   always #5 clk = ~clk;
   csc_regs #(.BLINK_CYCLES(BLINK)) csc_regs_i (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .reg_rvalid, .status_in, .voltage_limit_event, .current_limit_event, .watchdog_expired,
      .charge_monitor_select, .in_warm_zone, .timer_slow_request, .voltage_limit_irq, .current_limit_irq,
      .safety_timer_restart, .safety_timer_half_rate, .tz_cfg, .warm_current_pct, .fine_tune_mv, .offset_dv,
      .cool_ratio_bp, .warm_ratio_bp, .stat_pin_out, .stat_pin_oe_n);
   csc_host_model csc_host_model_i (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid);
   // ==========================================================
   // verdict and comparison helpers
   task automatic end_of_test();
      if (miscompares == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_of_test
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      csc_host_model_i.write(a, d, 0);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
      logic [7:0] d;
      int w;
      csc_host_model_i.read(a, d, w);
      check(16'(w), 16'h0, "read latency");
      if (w >= 4) begin
         end_of_test();
      end
      check(16'(d), 16'(exp), what);
   endtask : rd
   task automatic settle();
      repeat (3) @(posedge clk);
      #1;
   endtask : settle
   // ==========================================================
   // scenarios
   task automatic t_reset_values();
      rd(csc_pkg::ADDR_STATUS, 8'h00, "status rst");
      rd(csc_pkg::ADDR_TZCTL, 8'h75, "tzctl rst");
      rd(csc_pkg::ADDR_TZEN, 8'h01, "tzen rst");
      rd(csc_pkg::ADDR_FTLED, 8'h00, "ftled rst");
      rd(csc_pkg::ADDR_PART, part, "part rst");
      rd(csc_pkg::ADDR_RSVD, csc_pkg::RSVD_VALUE, "reserved");
   endtask : t_reset_values
   task automatic t_status();
      for (int i = 0; i < 32; i++) begin
         @(posedge clk);
         status_in <= 5'(i);
         rd(csc_pkg::ADDR_STATUS, {3'(i >> 2), 1'b0, 2'(i), 2'h0}, "status bits");
      end
      @(posedge clk);
      status_in <= '0;
   endtask : t_status
   task automatic t_masks();
      wr(csc_pkg::ADDR_PART, 8'h7f);
      wr(csc_pkg::ADDR_RSVD, 8'h5a);
      rd(csc_pkg::ADDR_PART, part, "part write");
      rd(csc_pkg::ADDR_RSVD, csc_pkg::RSVD_VALUE, "reserved write");
      rd(8'h10, 8'h00, "unmapped read");
      for (int m = 0; m < 4; m++) begin
         wr(csc_pkg::ADDR_STATUS, 8'hfc | 8'(m));
         rd(csc_pkg::ADDR_STATUS, 8'(m), "mask readback");
         @(posedge clk);
         voltage_limit_event <= 1'b1;
         current_limit_event <= 1'b1;
         @(posedge clk);
         voltage_limit_event <= 1'b0;
         current_limit_event <= 1'b0;
         #1;
         check(voltage_limit_irq, 16'(m < 2), "vlim irq");
         check(current_limit_irq, 16'(m % 2 == 0), "ilim irq");
         @(posedge clk);
         #1;
         check({voltage_limit_irq, current_limit_irq}, 16'h0, "irq width");
      end
   endtask : t_masks
   task automatic t_decode();
      logic [7:0] tz;
      for (int c = 0; c < 4; c++) begin
         tz = {c[0], c[1], c[1:0], c[1:0], c[1:0]};
         csc_host_model_i.write(csc_pkg::ADDR_TZCTL, tz, c);
         csc_host_model_i.write(csc_pkg::ADDR_TZEN, 8'h80 | 8'(c[0]), c);
         csc_host_model_i.write(csc_pkg::ADDR_FTLED, {c[1:0], 4'h0, c[1:0]}, 0);
         settle();
         check(tz_cfg, {tz, c[0]}, "tz cfg");
         check(warm_current_pct, 16'(pct[c]), "warm pct");
         check(cool_ratio_bp, 16'(cool[c]), "cool ratio");
         check(warm_ratio_bp, 16'(warm[c]), "warm ratio");
         check(16'(fine_tune_mv), 16'(ft[c]), "fine tune");
         check(offset_dv, 16'(offs[c]), "offset");
         rd(csc_pkg::ADDR_TZEN, 8'h80 | 8'(c[0]), "tzen readback");
      end
   endtask : t_decode
   task automatic t_reg_reset();
      wr(csc_pkg::ADDR_STATUS, 8'h03);
      wr(csc_pkg::ADDR_TZCTL, 8'h00);
      wr(csc_pkg::ADDR_FTLED, 8'hff);
      wr(csc_pkg::ADDR_PART, 8'h00);
      rd(csc_pkg::ADDR_TZCTL, 8'h00, "write zero keeps");
      wr(csc_pkg::ADDR_PART, 8'h80);
      @(posedge clk);
      #1;
      check(safety_timer_restart, 16'h1, "restart pulse");
      @(posedge clk);
      #1;
      check(safety_timer_restart, 16'h0, "restart end");
      rd(csc_pkg::ADDR_STATUS, 8'h00, "masks reset");
      rd(csc_pkg::ADDR_TZCTL, 8'h75, "tzctl reset");
      rd(csc_pkg::ADDR_TZEN, 8'h01, "tzen reset");
      rd(csc_pkg::ADDR_FTLED, 8'h00, "ftled reset");
      rd(csc_pkg::ADDR_PART, part, "cmd self clear");
   endtask : t_reg_reset
   task automatic t_watchdog();
      wr(csc_pkg::ADDR_STATUS, 8'h03);
      wr(csc_pkg::ADDR_TZCTL, 8'h00);
      wr(csc_pkg::ADDR_TZEN, 8'h00);
      wr(csc_pkg::ADDR_FTLED, 8'hff);
      @(posedge clk);
      watchdog_expired <= 1'b1;
      @(posedge clk);
      watchdog_expired <= 1'b0;
      settle();
      rd(csc_pkg::ADDR_TZCTL, 8'h75, "wdog tzctl");
      rd(csc_pkg::ADDR_TZEN, 8'h01, "wdog tzen");
      rd(csc_pkg::ADDR_FTLED, 8'h03, "wdog ftled");
      rd(csc_pkg::ADDR_STATUS, 8'h03, "wdog masks");
      wr(csc_pkg::ADDR_STATUS, 8'h00);
   endtask : t_watchdog
   task automatic t_timer();
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         {in_warm_zone, timer_slow_request} <= 2'(i);
         settle();
         check(safety_timer_half_rate, 16'(i == 1), "half rate");
      end
   endtask : t_timer
   task automatic t_stat_pin();
      int mon_t[7] = '{1, 1, 1, 1, 0, 2, 3};
      int mode_t[7] = '{0, 1, 2, 3, 1, 1, 1};
      int exp_t[7] = '{0, 64, 32, 16, 0, 0, 0};
      int n;
      for (int k = 0; k < 7; k++) begin
         @(posedge clk);
         charge_monitor_select <= 2'(mon_t[k]);
         wr(csc_pkg::ADDR_FTLED, 8'(mode_t[k] << 2));
         settle();
         n = 0;
         repeat (64) begin
            @(posedge clk);
            #1;
            if (led_level === 1'b0) begin
               n++;
            end
         end
         check(16'(n), 16'(exp_t[k]), "led low cycles");
         check(stat_pin_out, 16'h0, "pin pulls low only");
      end
   endtask : t_stat_pin
   // ==========================================================
   // main sequence and hang limit
   initial begin
      part = {1'b0, csc_pkg::PART_ID, csc_pkg::MAKER_FLAG, csc_pkg::REVISION};
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      t_reset_values();
      t_status();
      t_masks();
      t_decode();
      t_reg_reset();
      t_watchdog();
      t_timer();
      t_stat_pin();
      end_of_test();
   end
   initial begin
      #200_000;
      miscompares++;
      end_of_test();
   end
endmodule : charger_status_control_regs_tb
`default_nettype wire
